// >>> design/branch_bitop_exec.v
// execution unit for bit, skip and branch instructions with an apb register face
//
// Added by the designer: the register addresses and register access over APB.
`timescale 1ns/10ps
`include "bitop_exec_map.vh"
// Functional notes
// - swap operand nibbles, write back to memory
// - bank zero bit clear/set ignores bank
// - compare sets zero/carry, skips on equal
// - increment, to acc or memory, skip zero
// - decrement, to acc or memory, skip zero
// - bit test skips on clear or set
// - bank zero bit tests ignore bank select
// - jump: address field plus page bits, two cycles
// - call pushes full counter, then jumps
// - interrupt return also re-enables interrupts
// - push saves acc and flags, not status
// - pop restores acc and flags, keeps status
// - ram operand write, except clear, costs one extra cycle
// - true skip costs one extra cycle
module branch_bitop_exec (
  // apb slave
  input  wire        pclk,
  input  wire        presetn,
  input  wire        clk_en,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // core status
  output reg  [15:0] pc_q,
  output reg         busy_q
);
  localparam ST_IDLE = 3'b001;
  localparam ST_EXEC = 3'b010;
  localparam ST_WAIT = 3'b100;

  // register map seen by software, one aligned word each:
  //   0x00 control: write bit 0 to start, read bit 0 as busy
  //   0x04 instruction word: opcode, bit select, system register flag, address or immediate
  //   0x08 operand: the memory image that in-place forms write back
  //   0x0C status: bit 0 last skip, bit 1 done, bits 5:2 stack depth
  //   0x10 accumulator
  //   0x14 flags: zero, carry, interrupt enable, two status bits on top
  //   0x18 program counter in bits 15:0, page select in bits 17:16
  //   0x1C last result from the data path
  //   0x20 cycles taken by the last instruction
  //   0x24 bank select, reported only
  // anything else answers with an error and reads as zero

  // instruction word layout:
  //   bits 20:16 opcode
  //   bit  15    operand is a system register, so no ram write penalty
  //   bits 14:12 bit select for bit set, clear and test forms
  //   bits 13:0  branch target, bits 7:0 immediate for compare
  // fields overlap on purpose; each opcode reads only what it needs

  reg [2:0]  state_q;
  reg [20:0] instr_q;
  reg [7:0]  operand_q;
  reg [7:0]  acc_q;
  reg [7:0]  flags_q;
  reg [1:0]  page_q;
  reg [1:0]  bank_q;
  reg [7:0]  result_q;
  reg [2:0]  cyc_q;
  reg [2:0]  left_q;
  reg        skip_q;
  reg        done_q;
  reg [7:0]  save_acc_q;
  reg [7:0]  save_flags_q;
  // eight-entry return stack; the depth counts to eight but there is no
  // overflow or underflow guard, so a ninth call overwrites entry zero
  // and software is expected to keep calls balanced
  reg [3:0]  sp_q;
  reg [15:0] stack_q [0:`STACK_DEPTH-1];
  integer    i;

  wire [4:0] op      = instr_q[`OP_MSB:`OP_LSB];
  wire       sysreg  = instr_q[`SYSREG_BIT];
  wire [7:0] alu_res;
  wire       to_acc;
  wire       to_mem;
  wire       new_c;
  wire       upd_z;
  wire       upd_c;
  wire       skip;
  wire       zero;

  // address decode shared by read and write paths
  function [3:0] reg_index;
    input [7:0] a;
    begin
      reg_index = a[5:2];
      if (a[1:0] != 2'b00 || a > `REG_BANK)
        reg_index = 4'hF;
    end
  endfunction

  // the fixed-cost branch group
  function is_branch;
    input [4:0] o;
    begin
      is_branch = (o == `OP_JUMP) || (o == `OP_CALL) ||
                  (o == `OP_RETURN) || (o == `OP_IRET);
    end
  endfunction

  // ram write penalty: clear is a one-cycle op whatever its target
  function has_penalty;
    input [4:0] o;
    input       mem_wr;
    input       ram;
    begin
      has_penalty = mem_wr & ram & (o != `OP_ZERO_MEM);
    end
  endfunction

  // cycle cost: base, memory-write penalty, taken skip
  // the total never exceeds three, so a 3-bit count is enough
  function [2:0] cost;
    input [4:0] o;
    input       mem_wr;
    input       ram;
    input       skp;
    begin
      if (is_branch(o))
        cost = `CYC_BRANCH;
      else
        cost = `CYC_BASE + {2'b00, has_penalty(o, mem_wr, ram)} + {2'b00, skp};
    end
  endfunction

  bitop_alu u_alu (
    .op        (op),
    .bit_sel   (instr_q[`BIT_MSB:`BIT_LSB]),
    .imm       (instr_q[7:0]),
    .acc       (acc_q),
    .mem       (operand_q),
    .carry     (flags_q[`FLAG_C]),
    .result    (alu_res),
    .to_acc    (to_acc),
    .to_mem    (to_mem),
    .new_carry (new_c),
    .upd_z     (upd_z),
    .upd_c     (upd_c),
    .skip      (skip),
    .zero      (zero)
  );

  // cost of the instruction in execute, worked out once
  wire [2:0] cost_now = cost(op, to_mem, ~sysreg, skip);

  // bus strobes for the first access edge; the ~pready term keeps the
  // second access edge from applying a write or read a second time
  wire apb_wr = psel & penable & pwrite & ~pready;
  wire apb_rd = psel & penable & ~pwrite & ~pready;
  wire [3:0] idx = reg_index(paddr);

  // apb: one wait state, answer in the second access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (clk_en) begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & (idx == 4'hF);
      if (apb_rd) begin
        case (idx)
          4'h0: prdata <= {31'h0, busy_q};
          4'h1: prdata <= {11'h0, instr_q};
          4'h2: prdata <= {24'h0, operand_q};
          4'h3: prdata <= {24'h0, 2'h0, sp_q, done_q, skip_q};
          4'h4: prdata <= {24'h0, acc_q};
          4'h5: prdata <= {24'h0, flags_q};
          4'h6: prdata <= {14'h0, page_q, pc_q};
          4'h7: prdata <= {24'h0, result_q};
          4'h8: prdata <= {29'h0, cyc_q};
          4'h9: prdata <= {30'h0, bank_q};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // instruction sequencer and architectural state
  // idle accepts register writes and the start bit, execute applies the
  // data path result in one cycle, wait burns the remaining cycles so
  // busy stays high for exactly the instruction's cost; the counter is
  // loaded with cost minus one, so a one-cycle op never enters wait
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q      <= ST_IDLE;
      instr_q      <= 21'h0;
      operand_q    <= 8'h00;
      acc_q        <= 8'h00;
      // both status bits start set; push and pop never touch them
      flags_q      <= `RESET_FLAGS;
      page_q       <= 2'b00;
      bank_q       <= 2'b00;
      result_q     <= 8'h00;
      cyc_q        <= 3'h0;
      left_q       <= 3'h0;
      skip_q       <= 1'b0;
      done_q       <= 1'b0;
      save_acc_q   <= 8'h00;
      save_flags_q <= 8'h00;
      sp_q         <= 4'h0;
      pc_q         <= 16'h0000;
      busy_q       <= 1'b0;
      for (i = 0; i < `STACK_DEPTH; i = i + 1)
        stack_q[i] <= 16'h0000;
    end else if (clk_en) begin
      case (state_q)
        ST_IDLE: begin
          // software may load state only while idle
          if (apb_wr) begin
            case (idx)
              4'h0: if (pwdata[0]) begin
                state_q <= ST_EXEC;
                busy_q  <= 1'b1;
                done_q  <= 1'b0;
              end
              4'h1: instr_q   <= pwdata[20:0];
              4'h2: operand_q <= pwdata[7:0];
              4'h4: acc_q     <= pwdata[7:0];
              4'h5: flags_q   <= pwdata[7:0];
              4'h6: begin
                pc_q   <= pwdata[15:0];
                page_q <= pwdata[17:16];
              end
              4'h9: bank_q    <= pwdata[1:0];
              default: done_q <= done_q;
            endcase
          end
        end
        ST_EXEC: begin
          // the memory image is the operand register; bank select only
          // reports where the access lands, the system owns the ram itself
          result_q <= alu_res;
          skip_q   <= skip;
          if (to_acc)
            acc_q <= alu_res;
          if (to_mem)
            operand_q <= alu_res;
          if (upd_z)
            flags_q[`FLAG_Z] <= zero;
          if (upd_c)
            flags_q[`FLAG_C] <= new_c;
          // fall-through advance; the branch cases below override it
          pc_q <= pc_q + (skip ? 16'h0002 : 16'h0001);
          case (op)
            `OP_JUMP: pc_q <= {page_q, instr_q[`ADDR_MSB:0]};
            `OP_CALL: begin
              stack_q[sp_q[2:0]] <= pc_q + 16'h0001;
              sp_q <= sp_q + 4'h1;
              pc_q <= {page_q, instr_q[`ADDR_MSB:0]};
            end
            `OP_RETURN, `OP_IRET: begin
              pc_q <= stack_q[sp_q[2:0] - 3'h1];
              sp_q <= sp_q - 4'h1;
              if (op == `OP_IRET)
                flags_q[`FLAG_GIE] <= 1'b1;
            end
            `OP_PUSH: begin
              save_acc_q   <= acc_q;
              save_flags_q <= flags_q & `SAVE_MASK;
            end
            `OP_POP: begin
              acc_q   <= save_acc_q;
              flags_q <= (flags_q & ~`SAVE_MASK) | (save_flags_q & `SAVE_MASK);
            end
            default: done_q <= 1'b0;
          endcase
          cyc_q  <= cost_now;
          left_q <= cost_now - 3'h1;
          if (cost_now == 3'h1) begin
            state_q <= ST_IDLE;
            busy_q  <= 1'b0;
            done_q  <= 1'b1;
          end else begin
            state_q <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          // extra cycles for branches, ram writes and taken skips
          left_q <= left_q - 3'h1;
          if (left_q == 3'h1) begin
            state_q <= ST_IDLE;
            busy_q  <= 1'b0;
            done_q  <= 1'b1;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end
endmodule

// >>> design/bitop_exec_map.vh
// constants for the branch and bit-operation execution unit
`ifndef BITOP_EXEC_MAP_VH
`define BITOP_EXEC_MAP_VH
// apb register byte offsets
`define REG_CTRL       8'h00
`define REG_INSTR      8'h04
`define REG_OPERAND    8'h08
`define REG_STATUS     8'h0C
`define REG_ACC        8'h10
`define REG_FLAGS      8'h14
`define REG_PC         8'h18
`define REG_RESULT     8'h1C
`define REG_CYCLES     8'h20
`define REG_BANK       8'h24
// instruction register fields
`define OP_LSB         16
`define OP_MSB         20
`define BIT_LSB        12
`define BIT_MSB        14
`define SYSREG_BIT     15
`define ADDR_MSB       13
// opcodes
`define OP_NOP         5'h00
`define OP_SWAP_NIB    5'h01
`define OP_ROTR_ACC    5'h02
`define OP_ROTR_MEM    5'h03
`define OP_ROTL_ACC    5'h04
`define OP_ROTL_MEM    5'h05
`define OP_ZERO_MEM    5'h06
`define OP_BIT_ZERO    5'h07
`define OP_BIT_ONE     5'h08
`define OP_BANK0_ZERO  5'h09
`define OP_BANK0_ONE   5'h0A
`define OP_CMPI        5'h0B
`define OP_CMPM        5'h0C
`define OP_INC_ACC     5'h0D
`define OP_INC_MEM     5'h0E
`define OP_DEC_ACC     5'h0F
`define OP_DEC_MEM     5'h10
`define OP_SKIP_LOW    5'h11
`define OP_SKIP_HIGH   5'h12
`define OP_BANK0_LOW   5'h13
`define OP_BANK0_HIGH  5'h14
`define OP_JUMP        5'h15
`define OP_CALL        5'h16
`define OP_RETURN      5'h17
`define OP_IRET        5'h18
`define OP_PUSH        5'h19
`define OP_POP         5'h1A
// flag register bit positions
`define FLAG_Z         0
`define FLAG_C         1
`define FLAG_GIE       2
`define FLAG_PWRDN     6
`define FLAG_WDTO      7
`define SAVE_MASK      8'h3F
`define RESET_FLAGS    8'hC0
// timing in cycles
`define CYC_BASE       3'h1
`define CYC_BRANCH     3'h2
`define STACK_DEPTH    8
`endif

// >>> design/bitop_alu.v
// combinational data path for one instruction
`timescale 1ns/10ps
`include "bitop_exec_map.vh"
module bitop_alu (
  // instruction
  input  wire [4:0]  op,
  input  wire [2:0]  bit_sel,
  input  wire [7:0]  imm,
  // state
  input  wire [7:0]  acc,
  input  wire [7:0]  mem,
  input  wire        carry,
  // results
  output reg  [7:0]  result,
  output reg         to_acc,
  output reg         to_mem,
  output reg         new_carry,
  output reg         upd_z,
  output reg         upd_c,
  output reg         skip,
  output reg         zero
);
  reg [8:0] diff;

  // one case per opcode; flags only where the op defines them
  always @* begin
    diff      = {1'b0, acc} - {1'b0, (op == `OP_CMPI) ? imm : mem};
    result    = mem;
    to_acc    = 1'b0;
    to_mem    = 1'b0;
    new_carry = carry;
    upd_z     = 1'b0;
    upd_c     = 1'b0;
    skip      = 1'b0;
    case (op)
      `OP_SWAP_NIB: begin
        result = {mem[3:0], mem[7:4]};
        to_mem = 1'b1;
      end
      `OP_ROTR_ACC, `OP_ROTR_MEM: begin
        result    = {carry, mem[7:1]};
        new_carry = mem[0];
        upd_c     = 1'b1;
        to_acc    = (op == `OP_ROTR_ACC);
        to_mem    = (op == `OP_ROTR_MEM);
      end
      `OP_ROTL_ACC, `OP_ROTL_MEM: begin
        result    = {mem[6:0], carry};
        new_carry = mem[7];
        upd_c     = 1'b1;
        to_acc    = (op == `OP_ROTL_ACC);
        to_mem    = (op == `OP_ROTL_MEM);
      end
      `OP_ZERO_MEM: begin
        result = 8'h00;
        to_mem = 1'b1;
      end
      `OP_BIT_ZERO, `OP_BANK0_ZERO: begin
        result = mem & ~(8'h01 << bit_sel);
        to_mem = 1'b1;
      end
      `OP_BIT_ONE, `OP_BANK0_ONE: begin
        result = mem | (8'h01 << bit_sel);
        to_mem = 1'b1;
      end
      `OP_CMPI, `OP_CMPM: begin
        result    = diff[7:0];
        new_carry = ~diff[8]; // carry set means no borrow
        upd_z     = 1'b1;
        upd_c     = 1'b1;
        skip      = (diff[7:0] == 8'h00);
      end
      `OP_INC_ACC, `OP_INC_MEM: begin
        result = mem + 8'h01;
        to_acc = (op == `OP_INC_ACC);
        to_mem = (op == `OP_INC_MEM);
        skip   = (mem == 8'hFF);
      end
      `OP_DEC_ACC, `OP_DEC_MEM: begin
        result = mem - 8'h01;
        to_acc = (op == `OP_DEC_ACC);
        to_mem = (op == `OP_DEC_MEM);
        skip   = (mem == 8'h01);
      end
      `OP_SKIP_LOW, `OP_BANK0_LOW: skip = ~mem[bit_sel];
      `OP_SKIP_HIGH, `OP_BANK0_HIGH: skip = mem[bit_sel];
      default: result = mem;
    endcase
    zero = (result == 8'h00);
  end
endmodule

// >>> sim/branch_bitop_exec_properties.sv
// port-level assertions for the execution unit
`timescale 1ns/10ps
module branch_bitop_exec_properties (
  // apb slave side
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        clk_en,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // core status
  input wire logic [15:0] pc_q,
  input wire logic        busy_q
);
  logic [20:0] ins_q;
  logic [4:0]  op;
  logic        br;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // mirror the accepted instruction word; writes during busy are dropped by the slave
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) ins_q <= 21'h000000;
    else if (clk_en && psel && penable && pwrite && !pready && !busy_q && paddr == 8'h04) ins_q <= pwdata[20:0];
  end
  // jump, call and both returns share the fixed two-cycle cost
  assign op = ins_q[20:16];
  assign br = op == 5'h15 || op == 5'h16 || op == 5'h17 || op == 5'h18;
  sequence s_go; $rose(busy_q); endsequence
  sequence s_one; !busy_q; endsequence
  sequence s_two; busy_q ##1 !busy_q; endsequence
  AST_PREADY_PULSE: assert property (pready |=> !pready) else $error("pready held past one cycle");
  AST_ERR_RANGE: assert property (psel && pready && paddr > 8'h24 |-> pslverr) else $error("no error beyond map");
  AST_ERR_READY: assert property (pslverr |-> pready) else $error("error without ready");
  AST_BRANCH_TWO: assert property (s_go ##0 br |=> s_two) else $error("branch cost not two");
  AST_JUMP_PC: assert property ($fell(busy_q) && op == 5'h15 |-> pc_q[13:0] == ins_q[13:0])
    else $error("jump target not loaded");
  AST_NOP_ONE: assert property (s_go ##0 op == 5'h00 |=> s_one) else $error("idle op cost not one");
  AST_SWAP_COST: assert property (s_go ##0 op == 5'h01 |=> if (ins_q[15]) s_one else s_two)
    else $error("swap cost wrong");
  AST_BUSY_BOUND: assert property (s_go |-> ##[1:3] !busy_q) else $error("busy beyond three cycles");
endmodule
bind branch_bitop_exec branch_bitop_exec_properties chk (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .pc_q(pc_q), .busy_q(busy_q));

// >>> sim/apb_host.sv
// apb master that stands in for the software side
`timescale 1ns/10ps
module apb_host (
  // bus
  input  wire logic        pclk,
  input  wire logic        pready,
  input  wire logic        pslverr,
  input  wire logic [31:0] prdata,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata
);
  // idle bus from time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
  end
  // one transfer, entered just after an edge; an edge passes after release so calls never collide
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                      output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
endmodule

// >>> sim/branch_bitop_exec_bench.sv
// self-checking bench for the execution unit
`timescale 1ns/10ps
`include "bitop_exec_map.vh"
module branch_bitop_exec_bench;
  logic        pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, busy_q, er;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, dm;
  logic [15:0] pc_q;
  int          err_count, n_checks, cyc;
  localparam logic [4:0] op_swap = 5'h01, op_rotr = 5'h02, op_rotl = 5'h04, op_bitz = 5'h07, op_zbit1 = 5'h0A;
  localparam logic [4:0] op_incm = 5'h0E, op_deca = 5'h0F, op_decm = 5'h10, op_tst0 = 5'h11, op_tst1 = 5'h12;
  localparam logic [4:0] op_ztst0 = 5'h13, op_jump = 5'h15, op_iret = 5'h18, op_zero = 5'h06, op_back = 5'h17;
  branch_bitop_exec dut (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .pc_q, .busy_q);
  apb_host host (.pclk, .pready, .pslverr, .prdata, .psel, .penable, .pwrite, .paddr, .pwdata);
  // clock, reset and a hang guard
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      test_done;
    end
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rdr(input logic [7:0] a);
    host.xfer(1'b0, a, 32'h0, rd, er);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, dm, er);
  endtask
  // load operands, start, wait for busy to drop; bounded so a stuck core cannot hang here
  task automatic run(input logic [4:0] op, input logic [15:0] lo, input logic [7:0] m, input logic [7:0] a);
    int n;
    wr(`REG_ACC, {24'h0, a});
    wr(`REG_OPERAND, {24'h0, m});
    wr(`REG_INSTR, {11'h0, op, lo});
    wr(`REG_CTRL, 32'h1);
    n = 0;
    while (busy_q !== 1'b0 && n < 50) begin
      @(posedge pclk);
      n++;
    end
  endtask
  task automatic cost(input logic [2:0] c);
    rdr(`REG_CYCLES); chk("cycles", rd[2:0], c);
  endtask
  task automatic t_mem;
    rdr(`REG_FLAGS); chk("reset flags", rd[7:0], 8'hC0);
    run(op_swap, 16'h0010, 8'h3C, 0); rdr(`REG_OPERAND); chk("swap", rd[7:0], 8'hC3);
    cost(2);
    run(op_swap, 16'h8010, 8'h3C, 0); cost(1);
    run(op_incm, 16'h0010, 8'hFF, 0); rdr(`REG_OPERAND); chk("inc", rd[7:0], 8'h00);
    cost(3);
    run(op_deca, 16'h0010, 8'h01, 8'h55); rdr(`REG_ACC); chk("dec acc", rd[7:0], 8'h00);
    cost(2);
    run(op_decm, 16'h8010, 8'h05, 0); rdr(`REG_OPERAND); chk("dec mem", rd[7:0], 8'h04);
    cost(1);
    $display("memory test done");
  endtask
  task automatic t_cmp;
    run(`OP_CMPI, 16'h005B, 0, 8'h5A); rdr(`REG_FLAGS); chk("cmp ne", rd[1:0], 2'b00);
    cost(1);
    run(`OP_CMPI, 16'h005A, 0, 8'h5A); rdr(`REG_FLAGS); chk("cmp eq", rd[1:0], 2'b11);
    rdr(`REG_STATUS); chk("cmp skip", rd[0], 1'b1);
    run(op_rotr, 16'h0010, 8'h02, 0); rdr(`REG_ACC); chk("rot right", rd[7:0], 8'h81);
    run(op_rotl, 16'h0010, 8'h80, 0); rdr(`REG_ACC); chk("rot left", rd[7:0], 8'h00);
    rdr(`REG_FLAGS); chk("rot carry", rd[1], 1'b1);
    $display("compare test done");
  endtask
  task automatic t_bits;
    run(op_tst0, 16'h3010, 8'h08, 0); cost(1);
    run(op_tst1, 16'h3010, 8'h08, 0); cost(2);
    run(op_ztst0, 16'h3010, 8'h00, 0); cost(2);
    run(op_zbit1, 16'h7010, 8'h00, 0); rdr(`REG_OPERAND); chk("set bit", rd[7:0], 8'h80);
    run(op_bitz, 16'h7010, 8'hFF, 0); rdr(`REG_OPERAND); chk("clear bit", rd[7:0], 8'h7F);
    run(`OP_NOP, 16'h0000, 0, 0); cost(1);
    run(op_zero, 16'h0010, 8'h5A, 0); rdr(`REG_OPERAND); chk("clear", rd[7:0], 8'h00);
    cost(1);
    $display("bit test done");
  endtask
  task automatic t_flow;
    wr(`REG_PC, 32'h00020000);
    run(op_jump, 16'h1234, 0, 0); chk("jump pc", pc_q, 16'h9234);
    cost(2);
    run(`OP_CALL, 16'h0050, 0, 0); chk("call pc", pc_q, 16'h8050);
    run(op_iret, 16'h0000, 0, 0); chk("return pc", pc_q, 16'h9235);
    rdr(`REG_FLAGS); chk("gie", rd[2], 1'b1);
    run(`OP_CALL, 16'h0050, 0, 0);
    run(op_back, 16'h0000, 0, 0); chk("plain return pc", pc_q, 16'h9236);
    cost(2);
    run(`OP_PUSH, 16'h0000, 0, 8'h77); cost(1);
    run(`OP_POP, 16'h0000, 0, 8'h00); rdr(`REG_ACC); chk("pop acc", rd[7:0], 8'h77);
    rdr(`REG_FLAGS); chk("status kept", rd[7:6], 2'b11);
    rdr(8'h28); chk("unmapped err", er, 1'b1);
    chk("unmapped data", rd, 32'h0);
    $display("flow test done");
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // main sequence
  initial begin
    presetn = 1'b0;
    clk_en = 1'b1;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_mem;
    t_cmp;
    t_bits;
    t_flow;
    test_done;
  end
endmodule
